// File: hw/ocs_pkg.sv
// Package of constants and types for the output/current setpoint controller
// ==========================================================================
// How it works
// - Output command: 0 off, 1 on.
// - Output comes up enabled after reset.
// - Disable saves setpoints, then drives both to zero.
// - Enable reloads the saved setpoints.
// - Queries report saved setpoints while output disabled.
// - Output query returns 0 off, 1 on.
// - Setpoint above limit rejected, error -222 posted.
// - Setpoint query returns value, model max, or 0.
// - Limit above trip level rejected; query returns limit.
// - Triggered value above limit is refused.
// - Mode defaults fixed; list building accepted.
// - List mode runs list; list building gives error.
// - Fixed during list aborts and restores prior settings.
// - Normal list end keeps final step settings.
// - Mode query reports list while list runs.
// - Trip level above factory max rejected, -222.
// - Measured current above trip level asserts shutdown.
// - Trip query returns level, factory max, or 0.
// - Scale select: high full scale, low one tenth.
// - Range selection first disables the output.
// - Scale query returns 0 low, 1 high.
// - Triggered value held, applied on trigger, checked.
// - Triggered query returns value without applying it.
package ocs_pkg;

  // ========================================================================
  // Widths and limits
  localparam int          VW           = 16;
  localparam logic [15:0] CURRENT_SETPOINT_QUERY_MAX     = 16'hffff; // Model full-scale current
  localparam logic [15:0] PROT_MAX     = 16'hf000; // Factory trip max, arbitrary
  localparam logic [15:0] ZERO         = 16'h0000;
  localparam logic [15:0] SCALE_DIV    = 16'h000a; // Low scale divisor
  localparam logic [15:0] ERR_RANGE    = 16'hff22; // -222 in two's complement
  localparam logic [15:0] ERR_CMD      = 16'hff9c; // -100, command error

  // ========================================================================
  // Command codes
  typedef enum logic [3:0] {
    OCS_C_NOP    = 4'h0,
    OCS_C_OUTPUT_STATE_QUERY   = 4'h1, // output_enable_cmd
    OCS_C_CURRENT_SETPOINT_QUERY   = 4'h2, // current_setpoint_cmd
    OCS_C_CEIL   = 4'h3, // current_ceiling_cmd
    OCS_C_MODE   = 4'h4, // current_exec_mode_cmd
    OCS_C_TRIPLV = 4'h5, // overcurrent_trip_level_cmd
    OCS_C_SCALE  = 4'h6, // current_scale_select_cmd
    OCS_C_PEND   = 4'h7, // pending_current_value_cmd
    OCS_C_TRG    = 4'h8, // trigger_apply_cmd
    OCS_C_LSTBLD = 4'h9, // any list-building command
    OCS_C_VOLTAGE_SETPOINT_QUERY   = 4'ha  // voltage setpoint (from voltage path)
  } ocs_cmd_e;

  // Query codes
  typedef enum logic [3:0] {
    OCS_Q_OUTPUT_STATE_QUERY   = 4'h0, // output_state_query
    OCS_Q_CURRENT_SETPOINT_QUERY   = 4'h1, // current_setpoint_query
    OCS_Q_CEIL   = 4'h2,
    OCS_Q_MODE   = 4'h3, // current_exec_mode_query
    OCS_Q_TRIPLV = 4'h4, // overcurrent_trip_level_query
    OCS_Q_SCALE  = 4'h5, // current_scale_query
    OCS_Q_PEND   = 4'h6,
    OCS_Q_VOLTAGE_SETPOINT_QUERY   = 4'h7  // voltage_setpoint_query
  } ocs_qry_e;

  // Query argument
  localparam logic [1:0] ARG_VAL = 2'h0;
  localparam logic [1:0] ARG_MAX = 2'h1;
  localparam logic [1:0] ARG_MIN = 2'h2;

  // List state machine, Gray along idle -> run -> done
  typedef enum logic [1:0] {
    OCS_L_IDLE = 2'b00,
    OCS_L_RUN  = 2'b01,
    OCS_L_DONE = 2'b11
  } ocs_list_e;

  // Reset values
  localparam logic        RST_OUT_EN = 1'b1;
  localparam logic        RST_SCALE  = 1'b1;
  localparam logic [15:0] RST_CEIL   = 16'hf000;
  localparam logic [15:0] RST_PROT   = 16'hf000;

endpackage

// File: hw/ocs_range_chk.sv
// Range checker: value accepted only when not above a bound
`timescale 1ns/1ps
module ocs_range_chk
  import ocs_pkg::*;
(
  input  wire logic [15:0] value,
  input  wire logic [15:0] bound,
  output logic             ok
);

  // Unsigned compare; equal to the bound is accepted
  assign ok = (value <= bound);

endmodule

// File: hw/ocs_ctrl.sv
// Output enable and current setpoint command controller
`timescale 1ns/1ps
module ocs_ctrl
  import ocs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [15:0] cmd_value,
  input  wire logic        qry_valid,
  input  wire logic [3:0]  qry_code,
  input  wire logic [1:0]  qry_arg,
  input  wire logic        list_step_valid,
  input  wire logic [15:0] list_step_current_setpoint_query,
  input  wire logic        list_last,
  input  wire logic [15:0] meas_current_setpoint_query,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             err_valid,
  output logic [15:0]      err_code,
  output logic [15:0]      current_setpoint_query_applied,
  output logic [15:0]      voltage_setpoint_query_applied,
  output logic             out_enable,
  output logic             scale_high,
  output logic             list_running,
  output logic             breaker_trip
);

  // ========================================================================
  // State
  logic        out_en_q;
  logic [15:0] current_setpoint_query_q;
  logic [15:0] voltage_setpoint_query_q;
  logic [15:0] current_setpoint_query_save_q;
  logic [15:0] voltage_setpoint_query_save_q;
  logic [15:0] ceil_q;
  logic [15:0] prot_q;
  logic [15:0] pend_q;
  logic        scale_q;
  ocs_list_e   list_q;
  logic [15:0] pre_list_current_setpoint_query_q;
  logic        trip_q;
  logic [1:0]  meas_sync_q;
  logic [15:0] meas_s1_q;
  logic [15:0] meas_s2_q;

  logic        cmd_ok_current_setpoint_query;
  logic        cmd_ok_ceil;
  logic        cmd_ok_prot;
  logic        run;
  logic        rej;
  logic [15:0] rej_code;
  logic [15:0] current_setpoint_query_prog;
  logic [15:0] voltage_setpoint_query_prog;

  assign run = (list_q == OCS_L_RUN);

  // ========================================================================
  // Range checks; the pending value shares the setpoint check against the limit
  ocs_range_chk u_chk_current_setpoint_query (
    .value (cmd_value),
    .bound (ceil_q),
    .ok    (cmd_ok_current_setpoint_query)
  );

  ocs_range_chk u_chk_ceil (
    .value (cmd_value),
    .bound (prot_q),
    .ok    (cmd_ok_ceil)
  );

  ocs_range_chk u_chk_prot (
    .value (cmd_value),
    .bound (PROT_MAX),
    .ok    (cmd_ok_prot)
  );

  // Programmed values seen by queries: saved copy while disabled
  assign current_setpoint_query_prog = out_en_q ? current_setpoint_query_q : current_setpoint_query_save_q;
  assign voltage_setpoint_query_prog = out_en_q ? voltage_setpoint_query_q : voltage_setpoint_query_save_q;

  // ========================================================================
  // Rejection decode
  always_comb begin
    rej      = 1'b0;
    rej_code = ERR_RANGE;
    if (cmd_valid) begin
      case (cmd_code)
        OCS_C_CURRENT_SETPOINT_QUERY: rej = !cmd_ok_current_setpoint_query;
        OCS_C_PEND: rej = !cmd_ok_current_setpoint_query;
        OCS_C_CEIL: rej = !cmd_ok_ceil;
        OCS_C_TRIPLV: rej = !cmd_ok_prot;
        OCS_C_LSTBLD: begin
          rej      = run;
          rej_code = ERR_CMD;
        end
        default: rej = 1'b0;
      endcase
    end
  end

  // Error output, one pulse per rejected command
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      err_valid <= 1'b0;
      err_code  <= ZERO;
    end else begin
      err_valid <= rej;
      if (rej) begin
        err_code <= rej_code;
      end
    end
  end

  // ========================================================================
  // Output enable; range select forces it off first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      out_en_q <= RST_OUT_EN;
    end else if (cmd_valid && cmd_code == OCS_C_OUTPUT_STATE_QUERY) begin
      out_en_q <= cmd_value[0];
    end else if (cmd_valid && cmd_code == OCS_C_SCALE) begin
      out_en_q <= 1'b0;
    end
  end

  // Save copies taken at the moment of disable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      current_setpoint_query_save_q <= ZERO;
      voltage_setpoint_query_save_q <= ZERO;
    end else if (out_en_q && cmd_valid &&
                 ((cmd_code == OCS_C_OUTPUT_STATE_QUERY && !cmd_value[0]) ||
                  cmd_code == OCS_C_SCALE)) begin
      current_setpoint_query_save_q <= current_setpoint_query_q;
      voltage_setpoint_query_save_q <= voltage_setpoint_query_q;
    end else if (!out_en_q && cmd_valid && !rej) begin
      // Programming while off updates what will be restored
      if (cmd_code == OCS_C_CURRENT_SETPOINT_QUERY) begin
        current_setpoint_query_save_q <= cmd_value;
      end else if (cmd_code == OCS_C_VOLTAGE_SETPOINT_QUERY) begin
        voltage_setpoint_query_save_q <= cmd_value;
      end else if (cmd_code == OCS_C_TRG) begin
        current_setpoint_query_save_q <= pend_q;
      end
    end
  end

  // ========================================================================
  // Active current setpoint, list stepping and trigger
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      current_setpoint_query_q <= ZERO;
    end else if (cmd_valid && cmd_code == OCS_C_OUTPUT_STATE_QUERY) begin
      current_setpoint_query_q <= cmd_value[0] ? current_setpoint_query_save_q : ZERO;
      if (cmd_value[0] && out_en_q) begin
        current_setpoint_query_q <= current_setpoint_query_q;
      end
    end else if (cmd_valid && cmd_code == OCS_C_SCALE) begin
      current_setpoint_query_q <= ZERO;
    end else if (cmd_valid && cmd_code == OCS_C_MODE &&
                 !cmd_value[0] && run) begin
      current_setpoint_query_q <= pre_list_current_setpoint_query_q;
    end else if (run && list_step_valid && out_en_q) begin
      current_setpoint_query_q <= list_step_current_setpoint_query;
    end else if (out_en_q && cmd_valid && !rej) begin
      if (cmd_code == OCS_C_CURRENT_SETPOINT_QUERY) begin
        current_setpoint_query_q <= cmd_value;
      end else if (cmd_code == OCS_C_TRG) begin
        current_setpoint_query_q <= pend_q;
      end
    end
  end

  // Voltage setpoint, only for save/restore on enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      voltage_setpoint_query_q <= ZERO;
    end else if (cmd_valid && cmd_code == OCS_C_OUTPUT_STATE_QUERY) begin
      if (!cmd_value[0]) begin
        voltage_setpoint_query_q <= ZERO;
      end else if (!out_en_q) begin
        voltage_setpoint_query_q <= voltage_setpoint_query_save_q;
      end
    end else if (cmd_valid && cmd_code == OCS_C_SCALE) begin
      voltage_setpoint_query_q <= ZERO;
    end else if (out_en_q && cmd_valid && cmd_code == OCS_C_VOLTAGE_SETPOINT_QUERY) begin
      voltage_setpoint_query_q <= cmd_value;
    end
  end

  // ========================================================================
  // Limit, trip level, pending value and scale
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ceil_q  <= RST_CEIL;
      prot_q  <= RST_PROT;
      pend_q  <= ZERO;
      scale_q <= RST_SCALE;
    end else if (cmd_valid && !rej) begin
      case (cmd_code)
        OCS_C_CEIL:   ceil_q  <= cmd_value;
        OCS_C_TRIPLV: prot_q  <= cmd_value;
        OCS_C_PEND:   pend_q  <= cmd_value;
        OCS_C_SCALE:  scale_q <= cmd_value[0];
        default:      ceil_q  <= ceil_q;
      endcase
    end
  end

  // ========================================================================
  // List execution state; fixed is the default
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      list_q          <= OCS_L_IDLE;
      pre_list_current_setpoint_query_q <= ZERO;
    end else begin
      case (list_q)
        OCS_L_IDLE, OCS_L_DONE: begin
          if (cmd_valid && cmd_code == OCS_C_MODE && cmd_value[0]) begin
            list_q          <= OCS_L_RUN;
            pre_list_current_setpoint_query_q <= current_setpoint_query_q;
          end else begin
            list_q <= OCS_L_IDLE;
          end
        end
        OCS_L_RUN: begin
          if (cmd_valid && cmd_code == OCS_C_MODE && !cmd_value[0]) begin
            list_q <= OCS_L_IDLE;
          end else if (list_step_valid && list_last) begin
            list_q <= OCS_L_DONE;
          end
        end
        default: list_q <= OCS_L_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Measured current crosses in from the converter: two flops
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meas_s1_q   <= ZERO;
      meas_s2_q   <= ZERO;
      meas_sync_q <= 2'b00;
    end else begin
      meas_s1_q   <= meas_current_setpoint_query;
      meas_s2_q   <= meas_s1_q;
      meas_sync_q <= {meas_sync_q[0], 1'b1};
    end
  end

  // Breaker trip latches until reset; out_enable is not cleared by a trip
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trip_q <= 1'b0;
    end else if (meas_sync_q[1] && meas_s2_q > prot_q) begin
      trip_q <= 1'b1;
    end
  end

  // ========================================================================
  // Query answers, registered one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= ZERO;
    end else begin
      rsp_valid <= qry_valid;
      if (qry_valid) begin
        case (qry_code)
          OCS_Q_OUTPUT_STATE_QUERY:  rsp_data <= {15'h0000, out_en_q};
          OCS_Q_CURRENT_SETPOINT_QUERY: begin
            if (qry_arg == ARG_MAX) begin
              rsp_data <= CURRENT_SETPOINT_QUERY_MAX;
            end else if (qry_arg == ARG_MIN) begin
              rsp_data <= ZERO;
            end else begin
              rsp_data <= current_setpoint_query_prog;
            end
          end
          OCS_Q_CEIL:  rsp_data <= ceil_q;
          OCS_Q_MODE:  rsp_data <= {15'h0000, run};
          OCS_Q_TRIPLV: begin
            if (qry_arg == ARG_MAX) begin
              rsp_data <= PROT_MAX;
            end else if (qry_arg == ARG_MIN) begin
              rsp_data <= ZERO;
            end else begin
              rsp_data <= prot_q;
            end
          end
          OCS_Q_SCALE: rsp_data <= {15'h0000, scale_q};
          OCS_Q_PEND:  rsp_data <= pend_q;
          OCS_Q_VOLTAGE_SETPOINT_QUERY:  rsp_data <= voltage_setpoint_query_prog;
          default:     rsp_data <= ZERO;
        endcase
      end
    end
  end

  // ========================================================================
  // Outputs to the power stage; low scale is one tenth of full scale
  assign current_setpoint_query_applied = current_setpoint_query_q;
  assign voltage_setpoint_query_applied = voltage_setpoint_query_q;
  assign out_enable   = out_en_q;
  assign scale_high   = scale_q;
  assign list_running = run;
  assign breaker_trip = trip_q;

endmodule

// File: tb/ocs_ctrl_sva.sv
// Port assertions for the setpoint controller
`timescale 1ns/1ps
module ocs_ctrl_sva
  import ocs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [15:0] cmd_value,
  input wire logic        qry_valid,
  input wire logic [3:0]  qry_code,
  input wire logic [1:0]  qry_arg,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        err_valid,
  input wire logic [15:0] err_code,
  input wire logic [15:0] current_setpoint_query_applied,
  input wire logic [15:0] voltage_setpoint_query_applied,
  input wire logic        out_enable,
  input wire logic        scale_high,
  input wire logic        list_running
);
  // ==========
  // Decode and the dark-output step
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire c_out  = cmd_valid && cmd_code == OCS_C_OUTPUT_STATE_QUERY;
  wire c_mode = cmd_valid && cmd_code == OCS_C_MODE;
  sequence s_dark;
    !out_enable && current_setpoint_query_applied == ZERO && voltage_setpoint_query_applied == ZERO;
  endsequence
  // ==========
  // Output, scale, list and answer checks
  a_off_dark: assert property (c_out && !cmd_value[0] |=> s_dark)
    else $error("output off left drive on");
  a_on_enable: assert property (c_out && cmd_value[0] |=> out_enable)
    else $error("output on ignored");
  a_scale_dark: assert property (
    cmd_valid && cmd_code == OCS_C_SCALE
    |=> s_dark ##0 (scale_high == $past(cmd_value[0])))
    else $error("bad scale select");
  a_boot_state: assert property (
    $rose(rstn) |-> out_enable && scale_high) else $error("bad reset state");
  a_list_start: assert property (
    c_mode && cmd_value[0] |=> list_running) else $error("list not running");
  a_list_refuse: assert property (
    list_running && cmd_valid && cmd_code == OCS_C_LSTBLD
    |=> err_valid && err_code == ERR_CMD) else $error("list build taken");
  a_state_answer: assert property (
    qry_valid && !cmd_valid && qry_code == OCS_Q_OUTPUT_STATE_QUERY
    |=> rsp_valid && rsp_data == {15'h0, $past(out_enable)})
    else $error("bad output state answer");
  a_min_zero: assert property (
    qry_valid && qry_arg == ARG_MIN
    && (qry_code == OCS_Q_CURRENT_SETPOINT_QUERY || qry_code == OCS_Q_TRIPLV)
    |=> rsp_valid && rsp_data == ZERO) else $error("minimum not zero");
endmodule
bind ocs_ctrl ocs_ctrl_sva ocs_ctrl_sva_i (.clk_sys, .rstn, .cmd_valid,
  .cmd_code, .cmd_value, .qry_valid, .qry_code, .qry_arg, .rsp_valid,
  .rsp_data, .err_valid, .err_code, .current_setpoint_query_applied, .voltage_setpoint_query_applied,
  .out_enable, .scale_high, .list_running);

// File: tb/ocs_host.sv
// Remote host model issuing commands and queries
`timescale 1ns/1ps
module ocs_host
  import ocs_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             cmd_valid,
  output logic [3:0]       cmd_code,
  output logic [15:0]      cmd_value,
  output logic             qry_valid,
  output logic [3:0]       qry_code,
  output logic [1:0]       qry_arg,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code
);
  // ==========
  // Idle levels at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = OCS_C_NOP;
    cmd_value = 16'h0000;
    qry_valid = 1'b0;
    qry_code  = OCS_Q_OUTPUT_STATE_QUERY;
    qry_arg   = ARG_VAL;
  end
  // ==========
  // One strobe a request; answers stand one cycle, so read them then.
  // Released data shows the inverse so stale values cannot pass as good.
  task automatic send(input logic [3:0] c, input logic [15:0] v,
                      output logic [15:0] e);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_value = v;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_value = ~v;
    e = (err_valid === 1'b1) ? err_code : {15'h0, err_valid};
  endtask
  task automatic ask(input logic [3:0] c, input logic [1:0] a,
                     output logic [15:0] d);
    @(negedge clk_sys);
    qry_valid = 1'b1;
    qry_code  = c;
    qry_arg   = a;
    @(negedge clk_sys);
    qry_valid = 1'b0;
    qry_arg   = ~a;
    d = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the setpoint controller
`timescale 1ns/1ps
module tb
  import ocs_pkg::*;
;
  logic        clk_sys = 1'b0, rstn = 1'b0;
  logic        list_step_valid = 1'b0, list_last = 1'b0;
  logic [15:0] list_step_current_setpoint_query = 16'h0000, meas_current_setpoint_query = 16'h0000;
  logic        cmd_valid, qry_valid, rsp_valid, err_valid;
  logic        out_enable, scale_high, list_running, breaker_trip;
  logic [3:0]  cmd_code, qry_code;
  logic [1:0]  qry_arg;
  logic [15:0] cmd_value, rsp_data, err_code, current_setpoint_query_applied, voltage_setpoint_query_applied, d;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // ==========
  // Clock, device and remote host
  always #2 clk_sys = ~clk_sys;
  ocs_ctrl ocs_ctrl_i (.clk_sys, .rstn, .cmd_valid, .cmd_code, .cmd_value,
    .qry_valid, .qry_code, .qry_arg, .list_step_valid, .list_step_current_setpoint_query,
    .list_last, .meas_current_setpoint_query, .rsp_valid, .rsp_data, .err_valid, .err_code,
    .current_setpoint_query_applied, .voltage_setpoint_query_applied, .out_enable, .scale_high, .list_running,
    .breaker_trip);
  ocs_host ocs_host_i (.clk_sys, .cmd_valid, .cmd_code, .cmd_value,
    .qry_valid, .qry_code, .qry_arg, .rsp_valid, .rsp_data, .err_valid,
    .err_code);
  // ==========
  // Compare and request helpers; a command expects 0 or its error code
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] v,
                     input logic [15:0] e);
    ocs_host_i.send(c, v, d);
    chk(d, e);
  endtask
  task automatic qry(input logic [3:0] c, input logic [1:0] a,
                     input logic [15:0] e);
    ocs_host_i.ask(c, a, d);
    chk(d, e);
  endtask
  task automatic step(input logic [15:0] v, input logic last);
    @(negedge clk_sys);
    list_step_valid = 1'b1;
    list_step_current_setpoint_query  = v;
    list_last       = last;
    @(negedge clk_sys);
    list_step_valid = 1'b0;
    list_last       = 1'b0;
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far above the roughly 110 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
  // ==========
  // Scenarios: power-up, ceilings, pending value, output, scale, list, trip
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    qry(OCS_Q_OUTPUT_STATE_QUERY, ARG_VAL, 16'h0001);
    qry(OCS_Q_SCALE, ARG_VAL, 16'h0001);
    qry(OCS_Q_CURRENT_SETPOINT_QUERY, ARG_MAX, CURRENT_SETPOINT_QUERY_MAX);
    qry(OCS_Q_CURRENT_SETPOINT_QUERY, ARG_MIN, ZERO);
    qry(OCS_Q_TRIPLV, ARG_MAX, PROT_MAX);
    cmd(OCS_C_CURRENT_SETPOINT_QUERY, 16'h0100, ZERO);
    cmd(OCS_C_VOLTAGE_SETPOINT_QUERY, 16'h0200, ZERO);
    cmd(OCS_C_TRIPLV, 16'h0200, ZERO);
    cmd(OCS_C_TRIPLV, PROT_MAX + 16'h0001, ERR_RANGE);
    qry(OCS_Q_TRIPLV, ARG_VAL, 16'h0200);
    cmd(OCS_C_CEIL, 16'h0201, ERR_RANGE);
    cmd(OCS_C_CEIL, 16'h0200, ZERO);
    qry(OCS_Q_CEIL, ARG_VAL, 16'h0200);
    cmd(OCS_C_CURRENT_SETPOINT_QUERY, 16'h0201, ERR_RANGE);
    qry(OCS_Q_CURRENT_SETPOINT_QUERY, ARG_VAL, 16'h0100);
    cmd(OCS_C_PEND, 16'h0201, ERR_RANGE);
    cmd(OCS_C_PEND, 16'h0180, ZERO);
    qry(OCS_Q_PEND, ARG_VAL, 16'h0180);
    chk(current_setpoint_query_applied, 16'h0100);
    cmd(OCS_C_TRG, 16'h0000, ZERO);
    chk(current_setpoint_query_applied, 16'h0180);
    cmd(OCS_C_OUTPUT_STATE_QUERY, 16'h0000, ZERO);
    qry(OCS_Q_CURRENT_SETPOINT_QUERY, ARG_VAL, 16'h0180);
    qry(OCS_Q_VOLTAGE_SETPOINT_QUERY, ARG_VAL, 16'h0200);
    cmd(OCS_C_OUTPUT_STATE_QUERY, 16'h0001, ZERO);
    chk(voltage_setpoint_query_applied, 16'h0200);
    chk(current_setpoint_query_applied, 16'h0180);
    for (int i = 0; i < 2; i++) begin
      cmd(OCS_C_SCALE, 16'(i), ZERO);
      chk({15'h0, out_enable}, 16'h0000);
      qry(OCS_Q_SCALE, ARG_VAL, 16'(i));
      cmd(OCS_C_OUTPUT_STATE_QUERY, 16'h0001, ZERO);
    end
    cmd(OCS_C_LSTBLD, 16'h0000, ZERO);
    cmd(OCS_C_MODE, 16'h0001, ZERO);
    qry(OCS_Q_MODE, ARG_VAL, 16'h0001);
    cmd(OCS_C_LSTBLD, 16'h0000, ERR_CMD);
    step(16'h0050, 1'b0);
    chk(current_setpoint_query_applied, 16'h0050);
    cmd(OCS_C_MODE, 16'h0000, ZERO);
    chk(current_setpoint_query_applied, 16'h0180);
    cmd(OCS_C_MODE, 16'h0001, ZERO);
    step(16'h0060, 1'b1);
    chk(current_setpoint_query_applied, 16'h0060);
    qry(OCS_Q_MODE, ARG_VAL, 16'h0000);
    // Equal to the trip level must not trip; one above must, and stick
    meas_current_setpoint_query = 16'h0200;
    repeat (5) @(negedge clk_sys);
    chk({15'h0, breaker_trip}, 16'h0000);
    meas_current_setpoint_query = 16'h0201;
    repeat (5) @(negedge clk_sys);
    chk({15'h0, breaker_trip}, 16'h0001);
    meas_current_setpoint_query = 16'h0000;
    repeat (5) @(negedge clk_sys);
    chk({15'h0, breaker_trip}, 16'h0001);
    print_verdict();
  end
endmodule
